// ===== inc/usb_phy_evt_pkg.sv
// shared constants of the event, status, debug and test byte registers
package usb_phy_evt_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int EVT_W  = 5;
  localparam int LS_W   = 2;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RISE_WR  = 6'h0D;
  localparam logic [ADDR_W-1:0] ADDR_RISE_SET = 6'h0E;
  localparam logic [ADDR_W-1:0] ADDR_RISE_CLR = 6'h0F;
  localparam logic [ADDR_W-1:0] ADDR_FALL_WR  = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_FALL_SET = 6'h11;
  localparam logic [ADDR_W-1:0] ADDR_FALL_CLR = 6'h12;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 6'h13;
  localparam logic [ADDR_W-1:0] ADDR_LATCH    = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_DEBUG    = 6'h15;
  localparam logic [ADDR_W-1:0] ADDR_TEST_WR  = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_TEST_SET = 6'h17;
  localparam logic [ADDR_W-1:0] ADDR_TEST_CLR = 6'h18;

  // ---------------------------------------------------------------
  // event bit positions
  // ---------------------------------------------------------------
  localparam int BIT_ID_GROUNDED     = 4;
  localparam int BIT_SESSION_END     = 3;
  localparam int BIT_SESSION_VALID   = 2;
  localparam int BIT_BUS_POWER_VALID = 1;
  localparam int BIT_HOST_DISCONNECT = 0;
  localparam int BIT_LINE_STATE_HI   = 1;
  localparam int BIT_LINE_STATE_LO   = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [EVT_W-1:0]  RST_EDGE_EN = 5'h1F;
  localparam logic [EVT_W-1:0]  RST_LATCH   = 5'h00;
  localparam logic [DATA_W-1:0] RST_TEST    = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO   = 8'h00;

  // ---------------------------------------------------------------
  // write operations and synchroniser depth
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_SET, OP_CLEAR} wr_op_t;
  localparam int SYNC_STAGES = 3;

endpackage

// ===== inc/event_if.sv
// carrier between the register top and the edge latch
`timescale 1ns/100ps
`default_nettype none
interface event_if;
  import usb_phy_evt_pkg::*;
  logic [EVT_W-1:0] source;
  logic [EVT_W-1:0] riseEn;
  logic [EVT_W-1:0] fallEn;
  logic             clear;
  logic [EVT_W-1:0] latch;
  logic [EVT_W-1:0] changed;

  modport core (input source, input riseEn, input fallEn, input clear, output latch, output changed);
  modport ctrl (output source, output riseEn, output fallEn, output clear, input latch, input changed);
endinterface
`default_nettype wire

// ===== core/pin_sync.sv
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import usb_phy_evt_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] syncOut_d;

  // ---------------------------------------------------------------
  // per-bit agreement
  // ---------------------------------------------------------------
  // stage1 feeds only stage2, so no metastable value reaches the compare
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gBit
      assign syncOut_d[g] = (stage2_q[g] == stage3_q[g]) ? stage2_q[g] : syncOut[g];
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      syncOut  <= syncOut_d;
    end
  end

endmodule
`default_nettype wire

// ===== core/edge_event_latch.sv
// per-source edge detection with rise/fall enables and sticky latch bits
`timescale 1ns/100ps
`default_nettype none
module edge_event_latch
  import usb_phy_evt_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  event_if.core     evt
);

  logic [EVT_W-1:0] prev_q;
  logic [EVT_W-1:0] latch_q;
  logic [EVT_W-1:0] latch_d;
  logic [EVT_W-1:0] hit;

  // ---------------------------------------------------------------
  // edge qualification
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < EVT_W; g++) begin : gEvt
      assign hit[g] = (evt.source[g] & ~prev_q[g] & evt.riseEn[g])
                    | (~evt.source[g] & prev_q[g] & evt.fallEn[g]);
      // set wins over a clear in the same cycle
      assign latch_d[g] = hit[g] | (latch_q[g] & ~evt.clear);
    end
  endgenerate

  assign evt.latch   = latch_q;
  assign evt.changed = hit;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q  <= '0;
      latch_q <= RST_LATCH;
    end else begin
      prev_q  <= evt.source;
      latch_q <= latch_d;
    end
  end

endmodule
`default_nettype wire

// ===== core/usb_phy_event_status_regs.sv
// event source, event latch, line-state debug and test byte registers
//
// How it works
// - event source register at 13h, read only, upper three bits read zero
// - bit 4 of source register shows live id_grounded
// - bits 3..1 show session end, session valid, bus power valid comparators
// - bit 0 shows live host_disconnect_flag
// - event latch register at 14h, read only, resets to zero
// - latch bit sets on a source change its edge enable allows
// - latch bits sit at same positions as source bits
// - reading the latch register clears all its bits except any set by an edge in the same cycle
// - entering low-power state clears all latch bits except any set by an edge in the same cycle
// - debug register at 15h shows two line-state bits, rest zero
// - test byte reads 16h..18h; write replaces, set ORs, clear clears
// - test byte resets to 00h and steers nothing else
// - rise enable allows latch and command on 0 to 1, resets enabled
// - fall enable allows latch and command on 1 to 0, resets enabled
`timescale 1ns/100ps
`default_nettype none
module usb_phy_event_status_regs
  import usb_phy_evt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [DATA_W-1:0] regWdata,
  output var  logic [DATA_W-1:0] regRdata,
  output var  logic              regRvalid,
  // analogue detector outputs, asynchronous
  input  wire logic              id_grounded,
  input  wire logic              session_end_flag,
  input  wire logic              session_valid_signal,
  input  wire logic              bus_power_valid_signal,
  input  wire logic              host_disconnect_flag,
  input  wire logic              line_state_hi,
  input  wire logic              line_state_lo,
  // same-clock control
  input  wire logic              lowPowerEnter,
  // receive-command request towards the link framer
  output var  logic              rxCmdRequest,
  output var  logic [EVT_W-1:0]  rxCmdStatus
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // write / set / clear decode shared by three register groups
  function automatic wr_op_t decodeOp(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base,
                                      input logic wr);
    wr_op_t op;
    op = OP_NONE;
    if (wr && addr == base) begin
      op = OP_WRITE;
    end else if (wr && addr == base + 6'h01) begin
      op = OP_SET;
    end else if (wr && addr == base + 6'h02) begin
      op = OP_CLEAR;
    end
    return op;
  endfunction

  function automatic logic [DATA_W-1:0] applyOp(input logic [DATA_W-1:0] cur, input logic [DATA_W-1:0] wd,
                                                input wr_op_t op);
    logic [DATA_W-1:0] nxt;
    nxt = cur;
    case (op)
      OP_WRITE: nxt = wd;
      OP_SET:   nxt = cur | wd;
      OP_CLEAR: nxt = cur & ~wd;
      default:  nxt = cur;
    endcase
    return nxt;
  endfunction

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] rawEvt;
  logic [EVT_W-1:0] srcEvt;
  logic [LS_W-1:0]  rawLine;
  logic [LS_W-1:0]  lineState;

  assign rawEvt[BIT_ID_GROUNDED]     = id_grounded;
  assign rawEvt[BIT_SESSION_END]     = session_end_flag;
  assign rawEvt[BIT_SESSION_VALID]   = session_valid_signal;
  assign rawEvt[BIT_BUS_POWER_VALID] = bus_power_valid_signal;
  assign rawEvt[BIT_HOST_DISCONNECT] = host_disconnect_flag;
  assign rawLine[BIT_LINE_STATE_HI]  = line_state_hi;
  assign rawLine[BIT_LINE_STATE_LO]  = line_state_lo;

  pin_sync #(
    .WIDTH (EVT_W)
  ) uEvtSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (rawEvt),
    .syncOut (srcEvt)
  );

  pin_sync #(
    .WIDTH (LS_W)
  ) uLineSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (rawLine),
    .syncOut (lineState)
  );

  // ---------------------------------------------------------------
  // write decode and enable / test registers
  // ---------------------------------------------------------------
  wr_op_t riseOp;
  wr_op_t fallOp;
  wr_op_t testOp;

  logic [EVT_W-1:0]  riseEn_q;
  logic [EVT_W-1:0]  riseEn_d;
  logic [EVT_W-1:0]  fallEn_q;
  logic [EVT_W-1:0]  fallEn_d;
  logic [DATA_W-1:0] test_q;
  logic [DATA_W-1:0] test_d;
  logic [DATA_W-1:0] riseFull;
  logic [DATA_W-1:0] fallFull;

  assign riseOp   = decodeOp(regAddr, ADDR_RISE_WR, regWrite);
  assign fallOp   = decodeOp(regAddr, ADDR_FALL_WR, regWrite);
  assign testOp   = decodeOp(regAddr, ADDR_TEST_WR, regWrite);
  // reserved enable bits are not stored and read back zero
  assign riseFull = applyOp({3'h0, riseEn_q}, regWdata, riseOp);
  assign fallFull = applyOp({3'h0, fallEn_q}, regWdata, fallOp);
  assign riseEn_d = riseFull[EVT_W-1:0];
  assign fallEn_d = fallFull[EVT_W-1:0];
  assign test_d   = applyOp(test_q, regWdata, testOp);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      riseEn_q <= RST_EDGE_EN;
      fallEn_q <= RST_EDGE_EN;
      test_q   <= RST_TEST;
    end else begin
      riseEn_q <= riseEn_d;
      fallEn_q <= fallEn_d;
      test_q   <= test_d;
    end
  end

  // ---------------------------------------------------------------
  // event latch
  // ---------------------------------------------------------------
  event_if evt ();

  logic latchRead;

  assign latchRead  = regRead && (regAddr == ADDR_LATCH);
  assign evt.source = srcEvt;
  assign evt.riseEn = riseEn_q;
  assign evt.fallEn = fallEn_q;
  assign evt.clear  = latchRead | lowPowerEnter;

  edge_event_latch uLatch (
    .clk     (clk),
    .sys_rst (sys_rst),
    .evt     (evt)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // read data is sampled before the latch clear lands, so no event is lost
  logic [DATA_W-1:0] readMux;

  always_comb begin
    readMux = READ_ZERO;
    if (regAddr == ADDR_STATUS) begin
      readMux = {3'h0, srcEvt};
    end else if (regAddr == ADDR_LATCH) begin
      readMux = {3'h0, evt.latch};
    end else if (regAddr == ADDR_DEBUG) begin
      readMux = {6'h00, lineState};
    end else if (regAddr >= ADDR_TEST_WR && regAddr <= ADDR_TEST_CLR) begin
      readMux = test_q;
    end else if (regAddr >= ADDR_RISE_WR && regAddr <= ADDR_RISE_CLR) begin
      readMux = {3'h0, riseEn_q};
    end else if (regAddr >= ADDR_FALL_WR && regAddr <= ADDR_FALL_CLR) begin
      readMux = {3'h0, fallEn_q};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata  <= READ_ZERO;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= readMux;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive-command request
  // ---------------------------------------------------------------
  // the framer forwards every qualified change, which lets the link skip latch polls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxCmdRequest <= 1'b0;
      rxCmdStatus  <= '0;
    end else begin
      rxCmdRequest <= |evt.changed;
      rxCmdStatus  <= srcEvt;
    end
  end

endmodule
`default_nettype wire

// ===== tb/usb_phy_event_status_regs_asserts.sv
// checker of the status, latch, debug and test byte registers
`timescale 1ns/100ps
`default_nettype none
module usb_phy_event_status_regs_asserts
  import usb_phy_evt_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic              regRvalid,
  input wire logic              lowPowerEnter,
  input wire logic              rxCmdRequest,
  input wire logic [EVT_W-1:0]  rxCmdStatus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------
  // test byte shadow
  // ------
  logic [DATA_W-1:0] test_q;
  logic [DATA_W-1:0] test_d;
  wire logic rdStat = regRead && regAddr == ADDR_STATUS;
  wire logic rdLat  = regRead && regAddr == ADDR_LATCH;
  wire logic rdDbg  = regRead && regAddr == ADDR_DEBUG;
  wire logic rdTest = regRead && regAddr >= ADDR_TEST_WR && regAddr <= ADDR_TEST_CLR;
  wire logic wrT    = regWrite && regAddr == ADDR_TEST_WR;
  wire logic wrS    = regWrite && regAddr == ADDR_TEST_SET;
  wire logic wrC    = regWrite && regAddr == ADDR_TEST_CLR;
  assign test_d = wrT ? regWdata : wrS ? (test_q | regWdata) : wrC ? (test_q & ~regWdata) : test_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) test_q <= RST_TEST;
    else test_q <= test_d;
  end
  // ------
  // properties
  // ------
  property p_stat_res; rdStat |=> regRdata[7:5] == 3'h0; endproperty
  property p_stat_live; rdStat |=> regRdata[4:0] == rxCmdStatus; endproperty
  property p_latch_res; rdLat |=> regRdata[7:5] == 3'h0; endproperty
  // a fresh event in the clearing cycle survives, hence the request guard
  // the request seen with the second read reports the edge latched at the clear
  property p_rd_clear; rdLat ##1 (rdLat && !rxCmdRequest) |=> regRdata[4:0] == 5'h00; endproperty
  property p_lp_clear; lowPowerEnter ##1 (rdLat && !rxCmdRequest) |=> regRdata[4:0] == 5'h00; endproperty
  property p_dbg_res; rdDbg |=> regRdata[7:2] == 6'h00; endproperty
  property p_test; rdTest |=> regRdata == $past(test_q); endproperty
  property p_rvalid; regRead |=> regRvalid; endproperty
  property p_no_rvalid; !regRead |=> !regRvalid; endproperty
  a_stat_res: assert property (p_stat_res) else $error("status reserved bits set");
  a_stat_live: assert property (p_stat_live) else $error("status differs from sources");
  a_latch_res: assert property (p_latch_res) else $error("latch reserved bits set");
  a_rd_clear: assert property (p_rd_clear) else $error("latch kept after read");
  a_lp_clear: assert property (p_lp_clear) else $error("latch kept after low power");
  a_dbg_res: assert property (p_dbg_res) else $error("debug reserved bits set");
  a_test: assert property (p_test) else $error("test byte wrong");
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");
  c_dbl_read: cover property (rdLat ##1 rdLat);
  c_lp_read: cover property (lowPowerEnter ##1 rdLat);
  c_cmd: cover property (rxCmdRequest);
endmodule
bind usb_phy_event_status_regs usb_phy_event_status_regs_asserts i_chk (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
  .regRvalid(regRvalid), .lowPowerEnter(lowPowerEnter), .rxCmdRequest(rxCmdRequest), .rxCmdStatus(rxCmdStatus));
`default_nettype wire

// ===== tb/link_model.sv
// link controller model driving the register port
`timescale 1ns/100ps
`default_nettype none
module link_model
  import usb_phy_evt_pkg::*;
(
  input  wire logic              clk,
  output var  logic [ADDR_W-1:0] regAddr,
  output var  logic              regWrite,
  output var  logic              regRead,
  output var  logic [DATA_W-1:0] regWdata,
  input  wire logic [DATA_W-1:0] regRdata,
  input  wire logic              regRvalid
);
  initial begin
    regAddr = 6'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
    regWdata = 8'h00;
  end
  // ------
  // register access
  // ------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
    regWdata <= ~d; // idle data wanders so a stale byte cannot match
  endtask
  // latch read only on request; live changes also come as commands
  task automatic rd(input logic [ADDR_W-1:0] a, input int n, output logic [DATA_W-1:0] d,
                    output logic ok);
    ok = 1'h0;
    d = 8'h00;
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    repeat (n) @(posedge clk);
    regRead <= 1'h0;
    for (int k = 0; k < 4 && !ok; k++) begin
      #1;
      if (regRvalid === 1'h1) begin
        ok = 1'h1;
        d = regRdata;
      end else @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/usb_phy_event_status_regs_bench.sv
// self-checking bench of the register bank
`timescale 1ns/100ps
`default_nettype none
module usb_phy_event_status_regs_bench;
  import usb_phy_evt_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic [EVT_W-1:0]  src;
  logic              lsHi;
  logic              lsLo;
  logic              lowPowerEnter;
  wire  [ADDR_W-1:0] regAddr;
  wire               regWrite;
  wire               regRead;
  wire  [DATA_W-1:0] regWdata;
  wire  [DATA_W-1:0] regRdata;
  wire               regRvalid;
  wire               rxCmdRequest;
  wire  [EVT_W-1:0]  rxCmdStatus;
  logic [DATA_W-1:0] cmdSeen;
  int                mismatches = 0;
  int                cmpCount = 0;
  always #12.5 clk = ~clk;
  usb_phy_event_status_regs i_usb_phy_event_status_regs (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .id_grounded(src[4]), .session_end_flag(src[3]), .session_valid_signal(src[2]),
    .bus_power_valid_signal(src[1]), .host_disconnect_flag(src[0]), .line_state_hi(lsHi),
    .line_state_lo(lsLo), .lowPowerEnter(lowPowerEnter), .rxCmdRequest(rxCmdRequest),
    .rxCmdStatus(rxCmdStatus));
  link_model i_link_model (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  // ------
  // shared tasks
  // ------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input int n = 1);
    logic [DATA_W-1:0] d;
    logic              ok;
    i_link_model.rd(a, n, d, ok);
    if (ok !== 1'h1) begin
      mismatches++;
      $display("MISMATCH at %0t: no read answer", $time);
      end_of_test();
    end else begin
      check(d, exp);
    end
  endtask
  // sync path needs 4 edges, 8 leaves margin; command pulses are counted meanwhile
  task automatic drive(input int i, input logic v);
    @(posedge clk) src[i] <= v;
    cmdSeen = 8'h00;
    repeat (8) begin
      @(posedge clk);
      if (rxCmdRequest === 1'h1) cmdSeen = cmdSeen + 8'h01;
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic reset_values;
    rdChk(ADDR_STATUS, 8'h00);
    rdChk(ADDR_LATCH, 8'h00);
    rdChk(ADDR_DEBUG, 8'h00);
    rdChk(ADDR_TEST_WR, 8'h00);
    rdChk(ADDR_RISE_WR, 8'h1F);
    rdChk(ADDR_FALL_CLR, 8'h1F);
  endtask
  task automatic edge_walk;
    for (int i = 0; i < EVT_W; i++) begin
      drive(i, 1'h1);
      check(cmdSeen, 8'h01);
      check({3'h0, rxCmdStatus}, 8'h01 << i);
      rdChk(ADDR_STATUS, 8'h01 << i);
      rdChk(ADDR_LATCH, 8'h01 << i);
      rdChk(ADDR_LATCH, 8'h00, 2);
      drive(i, 1'h0);
      check(cmdSeen, 8'h01);
      rdChk(ADDR_LATCH, 8'h01 << i);
    end
    drive(0, 1'h1);
    // the read follows the low-power pulse directly
    @(posedge clk) lowPowerEnter <= 1'h1;
    fork
      @(posedge clk) lowPowerEnter <= 1'h0;
      rdChk(ADDR_LATCH, 8'h00);
    join
    drive(0, 1'h0);
    rdChk(ADDR_LATCH, 8'h01);
  endtask
  task automatic edge_mask;
    i_link_model.wr(ADDR_RISE_CLR, 8'h01);
    i_link_model.wr(ADDR_FALL_WR, 8'h1E);
    rdChk(ADDR_RISE_SET, 8'h1E);
    rdChk(ADDR_FALL_SET, 8'h1E);
    drive(0, 1'h1);
    check(cmdSeen, 8'h00);
    rdChk(ADDR_LATCH, 8'h00);
    rdChk(ADDR_STATUS, 8'h01);
    drive(0, 1'h0);
    drive(1, 1'h1);
    rdChk(ADDR_LATCH, 8'h02);
    i_link_model.wr(ADDR_RISE_SET, 8'h01);
    i_link_model.wr(ADDR_FALL_SET, 8'h01);
    drive(1, 1'h0);
    rdChk(ADDR_LATCH, 8'h02);
  endtask
  task automatic test_byte;
    i_link_model.wr(ADDR_TEST_WR, 8'hA5);
    rdChk(ADDR_TEST_CLR, 8'hA5);
    i_link_model.wr(ADDR_TEST_SET, 8'h0F);
    rdChk(ADDR_TEST_WR, 8'hAF);
    i_link_model.wr(ADDR_TEST_CLR, 8'hA0);
    rdChk(ADDR_TEST_SET, 8'h0F);
    i_link_model.wr(ADDR_STATUS, 8'hFF);
    i_link_model.wr(ADDR_LATCH, 8'hFF);
    rdChk(ADDR_STATUS, 8'h00);
    rdChk(ADDR_LATCH, 8'h00);
    rdChk(ADDR_RISE_WR, 8'h1F);
    rdChk(6'h3F, 8'h00);
  endtask
  task automatic line_state;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {lsHi, lsLo} <= i[1:0];
      repeat (8) @(posedge clk);
      rdChk(ADDR_DEBUG, {6'h00, i[1:0]});
    end
  endtask
  initial begin
    clk = 1'h0;
    sys_rst = 1'h1;
    src = 5'h00;
    lsHi = 1'h0;
    lsLo = 1'h0;
    lowPowerEnter = 1'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    reset_values();
    edge_walk();
    edge_mask();
    test_byte();
    line_state();
    end_of_test();
  end
endmodule
`default_nettype wire
